// ===== include/otp_pkg.sv
/*
  otp_pkg: register offsets, field positions, reset values, unlock keys,
  link states and timing counts for the one-time-programmable configuration bank.
  Assumes a 20 MHz system clock. The bank is reached only over the single-wire link.
*/
package otp_pkg;

  // ----------------------------------------
  // register offsets (six-bit link address)
  // ----------------------------------------
  localparam logic [5:0] ADDR_REV = 6'h00;
  localparam logic [5:0] ADDR_B1_POT = 6'h12;
  localparam logic [5:0] ADDR_B1_CTRL = 6'h13;
  localparam logic [5:0] ADDR_B1_THR1 = 6'h14;
  localparam logic [5:0] ADDR_B1_THR2 = 6'h15;
  localparam logic [5:0] ADDR_B1_UNLOCK = 6'h17;
  localparam logic [5:0] ADDR_B2_DRV = 6'h19;
  localparam logic [5:0] ADDR_B2_DUTY1 = 6'h1A;
  localparam logic [5:0] ADDR_B2_DUTY2 = 6'h1B;
  localparam logic [5:0] ADDR_B2_LOGIC = 6'h1C;
  localparam logic [5:0] ADDR_B2_UNLOCK = 6'h1E;
  localparam logic [5:0] ADDR_B1_CHK = 6'h21;
  localparam logic [5:0] ADDR_B2_CHK = 6'h22;
  localparam logic [5:0] ADDR_RAM_EN = 6'h2A;
  localparam logic [5:0] ADDR_RAM_LATCH = 6'h36;
  localparam logic [5:0] ADDR_B1_BURN = 6'h39;
  localparam logic [5:0] ADDR_B2_BURN = 6'h3A;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_DELAY_SEL = 6;
  localparam int POS_LO1_MODE = 4;
  localparam int POS_PWM_STYLE = 3;
  localparam int POS_PWM_FH = 2;
  localparam int POS_PWM_FL = 1;
  localparam int POS_PWM_ON = 0;
  localparam int POS_WIPER = 2;
  localparam int POS_STRETCH_EN = 1;
  localparam int POS_REG_VSEL = 0;
  localparam int POS_CMP_POL = 7;
  localparam int POS_STRETCH_POL = 6;
  localparam int POS_CMD_START = 7;
  localparam int POS_CMD_READ = 6;
  localparam int POS_DUTY1_MSB = 6;
  localparam int POS_DUTY2_MSB = 7;
  localparam int POS_CHK_CMP = 6;

  // ----------------------------------------
  // masks, keys, reset values
  // ----------------------------------------
  localparam logic [7:0] THR1_MASK = 8'h3F;
  localparam logic [7:0] LOGIC_MASK = 8'h0F;
  localparam logic [7:0] RAM_EN_KEY = 8'h3C;
  localparam logic [7:0] RAM_LATCH_KEY = 8'h96;
  localparam logic [7:0] BANK_UNLOCK_KEY = 8'h34;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // arbitrary neutral revision code
  localparam logic [7:0] REV_RESET = 8'h5A;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int POR_DLY0_MS = 8;
  localparam int POR_DLY1_MS = 12;
  localparam int POR_DLY2_MS = 16;
  localparam int POR_DLY3_MS = 40;
  localparam int POR_DLY0_CYC = POR_DLY0_MS * (CLK_HZ / 1000);
  localparam int POR_DLY1_CYC = POR_DLY1_MS * (CLK_HZ / 1000);
  localparam int POR_DLY2_CYC = POR_DLY2_MS * (CLK_HZ / 1000);
  localparam int POR_DLY3_CYC = POR_DLY3_MS * (CLK_HZ / 1000);
  localparam int POR_CNT_W = 20;

  // ----------------------------------------
  // link states
  // ----------------------------------------
  typedef enum logic [1:0] {
    OTP_CMD = 2'b00,
    OTP_WDATA = 2'b01,
    OTP_RDATA = 2'b10,
    OTP_SKIP = 2'b11
  } otp_state_t;

endpackage : otp_pkg

// ===== verilog/otp_config_bank.sv
/*
  otp_config_bank: configuration register bank behind the single-wire link,
  with the pin logic that the bank steers (pwm pin, logic output 1, comparator
  polarity, power-on delay). Assumes link slots already decoded into one-cycle
  strobes synchronous to clk_in, and an analog comparator and pwm oscillator outside.
*/
// Operation
// - the power-on delay is 8, 12, 16 or 40 ms by the two-bit select code 00..11.
// - logic output 1 is held low, held open, on while comparator high, or off while high.
// - the pwm pin is push-pull when the style bit is 0 and open-drain when it is 1.
// - with pwm enabled, force-high holds the pwm pin high; it is ignored when disabled.
// - with pwm enabled, force-low holds the pwm pin low unless force-high is also set; it is ignored when disabled.
// - the pwm pin is off when the enable bit is 0 and running when it is 1.
// - pulse stretching is applied only when the stretch-enable bit is 1.
// - the wiper tap is the six-bit field at bits 7:2 of the first bank-1 register.
// - threshold one is the six-bit field at bits 5:0 of offset 0x14.
// - threshold two is the six-bit field at bits 5:0 of offset 0x15.
// - the comparator output is inverted when bit 7 of offset 0x15 is 1.
// - bit 6 of offset 0x15 picks positive (0) or negative (1) pulses to stretch.
// - each access opens with a command byte: zero start bit, read bit, six-bit address.
// - command and data bytes travel most significant bit first both ways.
`timescale 1ns/1ns
module otp_config_bank
#(
  parameter int POR_CYC_0 = otp_pkg::POR_DLY0_CYC,
  parameter int POR_CYC_1 = otp_pkg::POR_DLY1_CYC,
  parameter int POR_CYC_2 = otp_pkg::POR_DLY2_CYC,
  parameter int POR_CYC_3 = otp_pkg::POR_DLY3_CYC,
  parameter logic [7:0] REV_CODE = otp_pkg::REV_RESET
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_reset_in,
  input wire logic link_slot_in,
  input wire logic link_data_in,
  output logic link_data_out,
  output logic link_oe_out,
  input wire logic cmp_raw_in,
  input wire logic pwm_osc_in,
  output logic pwm_data_out,
  output logic pwm_oe_out,
  output logic lo1_data_out,
  output logic lo1_oe_out,
  output logic comparator_out_out,
  output logic por_done_out,
  output logic ram_mode_out,
  output logic [5:0] wiper_tap_out,
  output logic stretch_enable_out,
  output logic stretch_polarity_out,
  output logic regulator_voltage_sel_out,
  output logic [5:0] threshold_one_out,
  output logic [5:0] threshold_two_out,
  output logic [8:0] duty_cycle_one_out,
  output logic [8:0] duty_cycle_two_out,
  output logic [5:0] driver_config_out,
  output logic [3:0] logic_outputs_cfg_out
);
  import otp_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    otp_state_t state;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [5:0] addr;
    logic [7:0] rev;
    logic [7:0] pot;
    logic [7:0] ctrl;
    logic [7:0] thr1;
    logic [7:0] thr2;
    logic [7:0] drv;
    logic [7:0] duty1_lo;
    logic [7:0] duty2_lo;
    logic [7:0] logic_cfg;
    logic [7:0] ram_key;
    logic [7:0] latch_key;
    logic [7:0] burn1;
    logic [7:0] burn2;
    logic ram_mode;
    logic b1_unl;
    logic b2_unl;
    logic [8:0] duty1;
    logic [8:0] duty2;
    logic [POR_CNT_W-1:0] por_cnt;
    logic por_done;
    logic cmp_out;
    logic lo1_oe;
    logic pwm_out;
    logic pwm_oe;
    logic dq_oe;
  } otp_regs_t;

  otp_regs_t st_q;
  otp_regs_t st_d;
  logic [7:0] slot_byte;
  logic byte_done;
  logic wr_fire;
  logic [7:0] rd_val;
  logic [POR_CNT_W-1:0] por_target;
  logic pwm_level;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  function automatic logic [7:0] read_mux(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_REV)
      v = st_q.rev;
    else if (a == ADDR_B1_POT)
      v = st_q.pot;
    else if (a == ADDR_B1_CTRL)
      v = st_q.ctrl;
    else if (a == ADDR_B1_THR1)
      v = st_q.thr1 & THR1_MASK;
    else if (a == ADDR_B1_THR2)
      v = st_q.thr2;
    else if (a == ADDR_B2_DRV)
      v = st_q.drv;
    else if (a == ADDR_B2_DUTY1)
      v = st_q.duty1_lo;
    else if (a == ADDR_B2_DUTY2)
      v = st_q.duty2_lo;
    else if (a == ADDR_B2_LOGIC)
      v = st_q.logic_cfg & LOGIC_MASK;
    else if (a == ADDR_B1_CHK || a == ADDR_B2_CHK)
      v[POS_CHK_CMP] = st_q.cmp_out;
    else if (a == ADDR_RAM_EN)
      v = st_q.ram_key;
    else if (a == ADDR_RAM_LATCH)
      v = st_q.latch_key;
    else if (a == ADDR_B1_BURN)
      v = st_q.burn1;
    else if (a == ADDR_B2_BURN)
      v = st_q.burn2;
    return v;
  endfunction : read_mux

  // ----------------------------------------
  // link decode helpers
  // ----------------------------------------
  assign slot_byte = {st_q.sh[6:0], link_data_in};
  assign byte_done = link_slot_in && !link_reset_in && (st_q.cnt == 3'h7);
  assign wr_fire = byte_done && (st_q.state == OTP_WDATA);
  // always_comb, not assign: the mux reads register state that is not an argument
  always_comb rd_val = read_mux(slot_byte[5:0]);

  // unlocking the delay select after power-up would change a running count;
  // the select is simply re-read every cycle until the delay has elapsed
  always_comb
  begin
    case (st_q.ctrl[POS_DELAY_SEL +: 2])
      2'b00: por_target = POR_CNT_W'(POR_CYC_0);
      2'b01: por_target = POR_CNT_W'(POR_CYC_1);
      2'b10: por_target = POR_CNT_W'(POR_CYC_2);
      default: por_target = POR_CNT_W'(POR_CYC_3);
    endcase
  end

  // force-high wins only if software breaks the exclusive use of both bits
  assign pwm_level = st_q.ctrl[POS_PWM_FH] ? 1'b1 :
                     st_q.ctrl[POS_PWM_FL] ? 1'b0 : pwm_osc_in;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (!st_q.por_done)
    begin
      if (st_q.por_cnt >= por_target - POR_CNT_W'(1))
        st_d.por_done = 1'b1;
      else
        st_d.por_cnt = st_q.por_cnt + POR_CNT_W'(1);
    end
    if (link_reset_in)
    begin
      st_d.state = OTP_CMD;
      st_d.cnt = 3'h0;
    end
    else if (link_slot_in)
    begin
      st_d.cnt = st_q.cnt + 3'h1;
      case (st_q.state)
        OTP_CMD:
        begin
          st_d.sh = slot_byte;
          if (byte_done)
          begin
            st_d.addr = slot_byte[5:0];
            if (slot_byte[POS_CMD_START])
              st_d.state = OTP_SKIP;
            else if (slot_byte[POS_CMD_READ])
            begin
              st_d.state = OTP_RDATA;
              st_d.sh = rd_val;
            end
            else
              st_d.state = OTP_WDATA;
          end
        end
        OTP_WDATA:
        begin
          st_d.sh = slot_byte;
          if (byte_done)
            st_d.state = OTP_CMD;
        end
        OTP_RDATA:
        begin
          st_d.sh = {st_q.sh[6:0], 1'b0};
          if (byte_done)
            st_d.state = OTP_CMD;
        end
        default: st_d.cnt = 3'h0;
      endcase
    end
    // bank writes land only in ram mode with the bank's key in place
    if (wr_fire)
    begin
      if (st_q.addr == ADDR_REV)
        st_d.rev = slot_byte;
      else if (st_q.addr == ADDR_B1_POT && st_q.b1_unl)
        st_d.pot = slot_byte;
      else if (st_q.addr == ADDR_B1_CTRL && st_q.b1_unl)
        st_d.ctrl = slot_byte;
      else if (st_q.addr == ADDR_B1_THR1 && st_q.b1_unl)
        st_d.thr1 = slot_byte & THR1_MASK;
      else if (st_q.addr == ADDR_B1_THR2 && st_q.b1_unl)
        st_d.thr2 = slot_byte;
      else if (st_q.addr == ADDR_B1_UNLOCK)
        st_d.b1_unl = st_q.ram_mode && (slot_byte == BANK_UNLOCK_KEY);
      else if (st_q.addr == ADDR_B2_DRV && st_q.b2_unl)
      begin
        // duty words only move when this register is written
        st_d.drv = slot_byte;
        st_d.duty1 = {slot_byte[POS_DUTY1_MSB], st_q.duty1_lo};
        st_d.duty2 = {slot_byte[POS_DUTY2_MSB], st_q.duty2_lo};
      end
      else if (st_q.addr == ADDR_B2_DUTY1 && st_q.b2_unl)
        st_d.duty1_lo = slot_byte;
      else if (st_q.addr == ADDR_B2_DUTY2 && st_q.b2_unl)
        st_d.duty2_lo = slot_byte;
      else if (st_q.addr == ADDR_B2_LOGIC && st_q.b2_unl)
        st_d.logic_cfg = slot_byte & LOGIC_MASK;
      else if (st_q.addr == ADDR_B2_UNLOCK)
        st_d.b2_unl = st_q.ram_mode && (slot_byte == BANK_UNLOCK_KEY);
      else if (st_q.addr == ADDR_RAM_EN)
        st_d.ram_key = slot_byte;
      else if (st_q.addr == ADDR_RAM_LATCH)
      begin
        st_d.latch_key = slot_byte;
        if (slot_byte == RAM_LATCH_KEY && st_q.ram_key == RAM_EN_KEY)
          st_d.ram_mode = 1'b1;
      end
      else if (st_q.addr == ADDR_B1_BURN)
        st_d.burn1 = slot_byte;
      else if (st_q.addr == ADDR_B2_BURN)
        st_d.burn2 = slot_byte;
    end
    // open drain: the line is pulled low for a zero data bit
    st_d.dq_oe = (st_d.state == OTP_RDATA) && !st_d.sh[7];
    st_d.cmp_out = cmp_raw_in ^ st_q.thr2[POS_CMP_POL];
    case (st_q.ctrl[POS_LO1_MODE +: 2])
      2'b00: st_d.lo1_oe = 1'b1;
      2'b01: st_d.lo1_oe = 1'b0;
      2'b10: st_d.lo1_oe = st_q.cmp_out;
      default: st_d.lo1_oe = !st_q.cmp_out;
    endcase
    st_d.pwm_out = st_q.ctrl[POS_PWM_ON] && !st_q.ctrl[POS_PWM_STYLE] && pwm_level;
    st_d.pwm_oe = st_q.ctrl[POS_PWM_ON] && (!st_q.ctrl[POS_PWM_STYLE] || !pwm_level);
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_q <= '0;
      st_q.rev <= REV_CODE;
    end
    else
      st_q <= st_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link_data_out = 1'b0;
  assign lo1_data_out = 1'b0;
  assign link_oe_out = st_q.dq_oe;
  assign pwm_data_out = st_q.pwm_out;
  assign pwm_oe_out = st_q.pwm_oe;
  assign lo1_oe_out = st_q.lo1_oe;
  assign comparator_out_out = st_q.cmp_out;
  assign por_done_out = st_q.por_done;
  assign ram_mode_out = st_q.ram_mode;
  assign wiper_tap_out = st_q.pot[POS_WIPER +: 6];
  assign stretch_enable_out = st_q.pot[POS_STRETCH_EN];
  assign stretch_polarity_out = st_q.thr2[POS_STRETCH_POL];
  assign regulator_voltage_sel_out = st_q.pot[POS_REG_VSEL];
  assign threshold_one_out = st_q.thr1[5:0];
  assign threshold_two_out = st_q.thr2[5:0];
  assign duty_cycle_one_out = st_q.duty1;
  assign duty_cycle_two_out = st_q.duty2;
  assign driver_config_out = st_q.drv[5:0];
  assign logic_outputs_cfg_out = st_q.logic_cfg[3:0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  por_hold_early_a: assert property (
    (!st_q.por_done && st_q.por_cnt < por_target - POR_CNT_W'(1)) |=> !por_done_out)
    else $error("power-on delay ended early");
  lo1_static_a: assert property (
    (st_q.ctrl[5:4] == 2'b00) |=> lo1_oe_out)
    else $error("logic output 1 not held low");
  lo1_open_a: assert property (
    (st_q.ctrl[5:4] == 2'b01) |=> !lo1_oe_out)
    else $error("logic output 1 not left open");
  pwm_drain_a: assert property (
    st_q.ctrl[POS_PWM_STYLE] |=> !pwm_data_out)
    else $error("open-drain pwm drove high");
  pwm_high_a: assert property (
    (st_q.ctrl[2:0] == 3'b101 && !st_q.ctrl[POS_PWM_STYLE]) |=> (pwm_data_out && pwm_oe_out))
    else $error("forced high not seen");
  pwm_low_a: assert property (
    (st_q.ctrl[2:0] == 3'b011 && !st_q.ctrl[POS_PWM_STYLE]) |=> (!pwm_data_out && pwm_oe_out))
    else $error("forced low not seen");
  pwm_off_a: assert property (
    !st_q.ctrl[POS_PWM_ON] |=> (!pwm_oe_out && !pwm_data_out))
    else $error("disabled pwm still driving");
  cmp_polarity_a: assert property (
    !$past(sys_rst_in)
      |-> (comparator_out_out == ($past(cmp_raw_in) ^ $past(st_q.thr2[POS_CMP_POL]))))
    else $error("comparator polarity wrong");
  thr1_zero_a: assert property (
    (wr_fire && st_q.addr == ADDR_B1_THR1) |=> (st_q.thr1[7:6] == 2'b00))
    else $error("threshold one upper bits stored");
  start_bit_a: assert property (
    (byte_done && st_q.state == OTP_CMD && slot_byte[7]) |=> (st_q.state == OTP_SKIP))
    else $error("bad start bit accepted");
  read_msb_a: assert property (
    (byte_done && st_q.state == OTP_CMD && slot_byte[7:6] == 2'b01)
      |=> (link_oe_out == !$past(rd_val[7])))
    else $error("read byte not msb first");
  ram_entry_a: assert property (
    (wr_fire && st_q.addr == ADDR_RAM_LATCH && slot_byte == RAM_LATCH_KEY
      && st_q.ram_key == RAM_EN_KEY) |=> ram_mode_out)
    else $error("ram mode not entered");
  ram_guard_a: assert property (
    (!st_q.ram_mode && !(wr_fire && st_q.addr == ADDR_RAM_LATCH)) |=> !ram_mode_out)
    else $error("ram mode entered without latch write");

  ram_entry_c: cover property (!ram_mode_out ##1 ram_mode_out);
  read_byte_c: cover property (st_q.state == OTP_RDATA && byte_done);
  force_high_c: cover property (pwm_oe_out && pwm_data_out && st_q.ctrl[POS_PWM_FH]);
  bank1_write_c: cover property (wr_fire && st_q.b1_unl && st_q.addr == ADDR_B1_CTRL);

endmodule : otp_config_bank

// ===== bench/otp_prog_model.sv
/*
  otp_prog_model: single-wire programmer model, driving decoded bit slots.
  assumes the bank samples slots on rising clk_in and pulls link_oe_in on reads.
*/
`timescale 1ns/1ns
module otp_prog_model
(
  input wire logic clk_in,
  input wire logic link_oe_in,
  output logic link_slot_out,
  output logic link_data_out,
  output logic link_reset_out
);
  initial
  begin
    link_slot_out = 1'b0;
    link_data_out = 1'b0;
    link_reset_out = 1'b0;
  end
  // one slot; data then shows the inverse so a stale bit never passes
  task automatic slot(input logic b);
    @(posedge clk_in);
    #2;
    link_slot_out = 1'b1;
    link_data_out = b;
    @(posedge clk_in);
    #2;
    link_slot_out = 1'b0;
    link_data_out = ~b;
  endtask : slot
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) slot(v[i]);
  endtask : send
  task automatic write_reg(input logic [5:0] a, input logic [7:0] v);
    send({2'b00, a});
    send(v);
  endtask : write_reg
  task automatic read_reg(input logic [5:0] a, output logic [7:0] v);
    send({2'b01, a});
    for (int i = 7; i >= 0; i--)
    begin
      v[i] = ~link_oe_in;
      slot(1'b1);
    end
  endtask : read_reg
  task automatic link_reset();
    @(posedge clk_in);
    #2;
    link_reset_out = 1'b1;
    @(posedge clk_in);
    #2;
    link_reset_out = 1'b0;
  endtask : link_reset
endmodule : otp_prog_model

// ===== bench/tb.sv
/*
  tb: self-checking bench for otp_config_bank driven through the programmer model.
  assumes a shortened power-on count for select 00 only; comparator and pwm oscillator are bench levels.
*/
`timescale 1ns/1ns
module tb;
  import otp_pkg::*;
  typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] r; logic osc; logic [2:0] p;} otp_row_t;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cmp_raw_in = 1'b1;
  logic pwm_osc_in = 1'b0;
  logic link_reset, link_slot, link_data, link_d, link_oe, pwm_d, pwm_oe, lo1_d, lo1_oe;
  logic cmp_o, por_done, ram_mode, st_en, st_pol, vsel;
  logic [5:0] wiper, thr1, thr2, drv;
  logic [8:0] duty1, duty2;
  logic [3:0] lcfg;
  logic [7:0] rd;
  int errors = 0;
  int total_checks = 0;
  otp_row_t rows[15];
  always #25 clk_in = ~clk_in;
  otp_prog_model prog (.clk_in(clk_in), .link_oe_in(link_oe), .link_slot_out(link_slot),
    .link_data_out(link_data), .link_reset_out(link_reset));
  otp_config_bank #(.POR_CYC_0(8)) i_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_reset_in(link_reset),
    .link_slot_in(link_slot), .link_data_in(link_data), .link_data_out(link_d),
    .link_oe_out(link_oe), .cmp_raw_in(cmp_raw_in), .pwm_osc_in(pwm_osc_in),
    .pwm_data_out(pwm_d), .pwm_oe_out(pwm_oe), .lo1_data_out(lo1_d), .lo1_oe_out(lo1_oe),
    .comparator_out_out(cmp_o), .por_done_out(por_done), .ram_mode_out(ram_mode),
    .wiper_tap_out(wiper), .stretch_enable_out(st_en), .stretch_polarity_out(st_pol),
    .regulator_voltage_sel_out(vsel), .threshold_one_out(thr1), .threshold_two_out(thr2),
    .duty_cycle_one_out(duty1), .duty_cycle_two_out(duty2), .driver_config_out(drv),
    .logic_outputs_cfg_out(lcfg));
  task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // rows: comparator raw 1 with inverted polarity, so it reads low
  // ----------------------------------------
  initial
  begin
    rows[0] = '{6'h00, 8'h11, 8'h11, 1'b0, 3'h0};
    rows[1] = '{6'h12, 8'hA5, 8'hA5, 1'b0, 3'h0};
    rows[2] = '{6'h14, 8'hFF, 8'h3F, 1'b0, 3'h0};
    rows[3] = '{6'h15, 8'hC7, 8'hC7, 1'b0, 3'h0};
    rows[4] = '{6'h1C, 8'hFF, 8'h0F, 1'b0, 3'h0};
    rows[5] = '{6'h05, 8'h77, 8'h00, 1'b0, 3'h0};
    rows[6] = '{6'h17, 8'h34, 8'h00, 1'b0, 3'h0};
    rows[7] = '{6'h13, 8'h00, 8'h00, 1'b0, 3'h1};
    rows[8] = '{6'h13, 8'h04, 8'h04, 1'b1, 3'h1};
    rows[9] = '{6'h13, 8'h11, 8'h11, 1'b1, 3'h6};
    rows[10] = '{6'h13, 8'h15, 8'h15, 1'b0, 3'h6};
    rows[11] = '{6'h13, 8'h23, 8'h23, 1'b1, 3'h4};
    rows[12] = '{6'h13, 8'h39, 8'h39, 1'b1, 3'h1};
    rows[13] = '{6'h13, 8'h0D, 8'h0D, 1'b0, 3'h1};
    rows[14] = '{6'h13, 8'h0B, 8'h0B, 1'b1, 3'h5};
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    $display("watchdog expired");
    conclude();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_in);
    #2;
    sys_rst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #2;
    check("por_done early", 9'h0, 9'(por_done));
    check("link_oe idle", 9'h0, 9'(link_oe));
    repeat (8) @(posedge clk_in);
    #2;
    check("por_done after 8", 9'h1, 9'(por_done));
    prog.read_reg(ADDR_REV, rd);
    check("revision", 9'(REV_RESET), 9'(rd));
    prog.write_reg(ADDR_B1_THR1, 8'h11);
    prog.read_reg(ADDR_B1_THR1, rd);
    check("locked thr1", 9'h0, 9'(rd));
    prog.write_reg(ADDR_RAM_LATCH, RAM_LATCH_KEY);
    check("latch alone", 9'h0, 9'(ram_mode));
    prog.write_reg(ADDR_RAM_EN, RAM_EN_KEY);
    prog.write_reg(ADDR_RAM_LATCH, RAM_LATCH_KEY);
    check("ram mode", 9'h1, 9'(ram_mode));
    prog.write_reg(ADDR_B1_UNLOCK, BANK_UNLOCK_KEY);
    prog.write_reg(ADDR_B2_UNLOCK, BANK_UNLOCK_KEY);
    $display("test reset and unlock done");
    foreach (rows[i])
    begin
      pwm_osc_in = rows[i].osc;
      prog.write_reg(rows[i].a, rows[i].w);
      prog.read_reg(rows[i].a, rd);
      check("readback", 9'(rows[i].r), 9'(rd));
      if (rows[i].a == ADDR_B1_CTRL)
        check("pwm oe, pwm data, lo1 oe", 9'(rows[i].p), 9'({pwm_oe, pwm_d, lo1_oe}));
    end
    $display("test rows done");
    check("wiper", 9'h29, 9'(wiper));
    check("stretch off", 9'h0, 9'(st_en));
    check("thr1", 9'h3F, 9'(thr1));
    check("thr2", 9'h07, 9'(thr2));
    check("stretch neg", 9'h1, 9'(st_pol));
    check("cmp inverted", 9'h0, 9'(cmp_o));
    check("regulator select", 9'h1, 9'(vsel));
    check("link and lo1 data", 9'h0, 9'({link_d, lo1_d}));
    // bad start bit: everything ignored until the link reset
    prog.send(8'h92);
    prog.send(8'h00);
    prog.link_reset();
    prog.read_reg(ADDR_B1_POT, rd);
    check("bad start", 9'hA5, 9'(rd));
    $display("test bad start done");
    prog.write_reg(ADDR_B1_POT, 8'h02);
    check("stretch on", 9'h1, 9'(st_en));
    check("regulator select off", 9'h0, 9'(vsel));
    prog.write_reg(ADDR_B1_THR2, 8'h05);
    cmp_raw_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #2;
    check("cmp normal", 9'h0, 9'(cmp_o));
    check("stretch pos", 9'h0, 9'(st_pol));
    // comparator high with normal polarity, on the pin and in the check register
    cmp_raw_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #2;
    check("cmp normal high", 9'h1, 9'(cmp_o));
    prog.read_reg(ADDR_B1_CHK, rd);
    check("check register", 9'h040, 9'(rd));
    $display("test polarity done");
    // duty words move only when the driver register is written
    prog.write_reg(ADDR_B2_DUTY1, 8'h55);
    prog.write_reg(ADDR_B2_DUTY2, 8'hAA);
    check("duty one held", 9'h000, duty1);
    prog.write_reg(ADDR_B2_DRV, 8'hC5);
    check("duty one", 9'h155, duty1);
    check("duty two", 9'h1AA, duty2);
    check("driver config", 9'h005, 9'(drv));
    check("logic outputs", 9'h00F, 9'(lcfg));
    $display("test duty done");
    // second reset in mid-run: ram mode, pins and power-on count start over
    sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #2;
    sys_rst_in = 1'b0;
    check("ram mode cleared", 9'h0, 9'(ram_mode));
    check("pwm oe cleared", 9'h0, 9'(pwm_oe));
    check("por_done cleared", 9'h0, 9'(por_done));
    repeat (12) @(posedge clk_in);
    #2;
    check("por_done again", 9'h1, 9'(por_done));
    prog.read_reg(ADDR_REV, rd);
    check("revision again", 9'(REV_RESET), 9'(rd));
    $display("test second reset done");
    conclude();
  end
endmodule : tb
